// ===== rtl/cld_defines.svh
// Purpose: constants of the character display instruction decoder
// Assumes: 250 MHz pclk, APB register access
// Notes: times kept in their printed units, cycle counts derived
`ifndef CLD_DEFINES_SVH
`define CLD_DEFINES_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CLD_OFF_HOST_CMD 12'h000
`define CLD_OFF_HOST_DATA 12'h004
`define CLD_OFF_READBACK 12'h008
`define CLD_OFF_MODE 12'h00c
`define CLD_OFF_SHIFT 12'h010
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define CLD_RB_VALID_BIT 8
`define CLD_SPACE_CODE 8'h20
`define CLD_AC_HOME 7'h00
`define CLD_LINE1_LAST 7'h27
`define CLD_LINE2_FIRST 7'h40
`define CLD_LINE2_LAST 7'h67
`define CLD_ONE_LINE_LAST 7'h4f
// ----------------------------------------
// timing (oscillator scaled to pclk)
// ----------------------------------------
`define CLD_LONG_NS 760000
`define CLD_SHORT_NS 18500
`define CLD_BLINK_NS 185000000
`define CLD_PCLK_NS 4
`define CLD_LONG_CYC (`CLD_LONG_NS / `CLD_PCLK_NS)
`define CLD_SHORT_CYC (`CLD_SHORT_NS / `CLD_PCLK_NS)
`define CLD_BLINK_CYC (`CLD_BLINK_NS / `CLD_PCLK_NS)
`endif

// ===== rtl/cld_pkg.sv
// Purpose: types of the character display instruction decoder
// Assumes: nothing
// Notes: the decoded instruction travels as one struct
package cld_pkg;
  typedef enum logic [3:0] {
    CLD_I_NONE, CLD_I_CLEAR, CLD_I_HOME, CLD_I_ENTRY, CLD_I_DISP,
    CLD_I_SHIFT, CLD_I_FUNC, CLD_I_GLYPH_ADDR, CLD_I_TEXT_ADDR
  } cld_instr_t;
  typedef struct packed {
    cld_instr_t kind;
    logic [6:0] arg;
  } cld_cmd_t;
  typedef struct packed {
    logic entry_inc;
    logic entry_shift;
    logic disp_on;
    logic cursor_on;
    logic blink_on;
    logic bus_width_select;
    logic two_line;
    logic font_tall;
  } cld_mode_t;
endpackage

// ===== rtl/cld_cmd_decode.sv
// Purpose: decode an instruction byte by its leading one
// Assumes: caller holds register_select low for instructions
// Notes: combinational, no state
`timescale 1ns/100ps
`include "cld_defines.svh"
module cld_cmd_decode
  import cld_pkg::*;
(
  input wire logic [7:0] cmd_byte,
  output cld_cmd_t cmd
);
  always_comb
  begin
    cmd.arg = cmd_byte[6:0];
    // leading one picks the instruction, lower bits are its fields
    if (cmd_byte[7])
      cmd.kind = CLD_I_TEXT_ADDR;
    else if (cmd_byte[6])
      cmd.kind = CLD_I_GLYPH_ADDR;
    else if (cmd_byte[5])
      cmd.kind = CLD_I_FUNC;
    else if (cmd_byte[4])
      cmd.kind = CLD_I_SHIFT;
    else if (cmd_byte[3])
      cmd.kind = CLD_I_DISP;
    else if (cmd_byte[2])
      cmd.kind = CLD_I_ENTRY;
    else if (cmd_byte[1])
      cmd.kind = CLD_I_HOME;
    else if (cmd_byte[0])
      cmd.kind = CLD_I_CLEAR;
    else
      cmd.kind = CLD_I_NONE;
  end
endmodule // cld_cmd_decode

// ===== rtl/cld_busy_timer.sv
// Purpose: busy flag down-counter
// Assumes: start pulses only while idle
// Notes: long and short counts are parameters so a bench can shorten them
`timescale 1ns/100ps
`include "cld_defines.svh"
module cld_busy_timer #(
  parameter int LONG_CYC = `CLD_LONG_CYC,
  parameter int SHORT_CYC = `CLD_SHORT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic start_long,
  output logic busy
);
  logic [17:0] cnt_q;
  initial
  begin
    if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC || LONG_CYC >= (1 << 18))
      $error("cld_busy_timer: bad counts");
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 18'h0;
    else if (start)
      cnt_q <= start_long ? 18'(LONG_CYC) : 18'(SHORT_CYC);
    else if (cnt_q != 18'h0)
      cnt_q <= cnt_q - 18'h1;
  end
  assign busy = (cnt_q != 18'h0);
endmodule // cld_busy_timer

// ===== rtl/cld_lcd_decoder.sv
// Purpose: instruction decoder and address counter of a character display controller
// Assumes: host transfers arrive as APB writes/reads; 250 MHz pclk
// Notes: nibble mode pairs two APB writes, high nibble first
//
// Functional notes
// - clear fills text ram with spaces, home
// - home zeroes counter and undoes shift
// - entry direction steps counter up or down
// - shift display on text writes when enabled
// - display enable blanks without losing text
// - cursor enable hides cursor, direction kept
// - blink toggles cursor cell at set interval while display and cursor enabled
// - shift command moves cursor or display
// - two-line cursor wraps line one to two
// - display shift leaves counter unchanged
// - width bit picks eight or four-bit bus
// - line and font bits pick format
// - address sets load counter, choose ram
// - text address range depends on lines
// - status read gives busy and counter
// - data write stores byte, steps counter
// - first read without address set invalid
// - cursor shift preloads read register too while text ram is selected
// - write leaves stale read register
// - busy lasts long or short by command
// - nibbles high first, busy after second
`timescale 1ns/100ps
`include "cld_defines.svh"
module cld_lcd_decoder
  import cld_pkg::*;
#(
  parameter int LONG_CYC = `CLD_LONG_CYC,
  parameter int SHORT_CYC = `CLD_SHORT_CYC,
  parameter int BLINK_CYC = `CLD_BLINK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output cld_mode_t mode_out,
  output logic [6:0] disp_shift_out,
  output logic cursor_cell_lit
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] text_ram [0:127];
  logic [7:0] glyph_ram [0:63];
  cld_mode_t mode_q;
  logic [6:0] address_counter_q;
  logic glyph_sel_q;
  logic [6:0] shift_q;
  logic [7:0] rd_reg_q;
  logic rd_valid_q;
  logic nib_half_q;
  logic [3:0] nib_hi_q;
  logic clr_busy_q;
  logic [6:0] clr_idx_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic blink_phase_q;
  logic [26:0] blink_cnt_q;
  logic busy_flag;
  cld_cmd_t cmd;
  initial
  begin
    if (BLINK_CYC < 2 || BLINK_CYC >= (1 << 27))
      $error("cld_lcd_decoder: bad blink count");
  end
  // ----------------------------------------
  // apb decode and nibble pairing
  // ----------------------------------------
  logic acc;
  logic wr_cmd;
  logic wr_data;
  logic rd_data;
  logic [7:0] byte_in;
  logic byte_done;
  logic host_ok;
  assign acc = psel && penable && !pready_q;
  assign host_ok = !busy_flag && !clr_busy_q;
  // nibble mode: upper four lines only, high nibble first
  assign byte_done = mode_q.bus_width_select || nib_half_q;
  assign byte_in = mode_q.bus_width_select ? pwdata[7:0] : {nib_hi_q, pwdata[7:4]};
  assign wr_cmd = acc && pwrite && paddr == `CLD_OFF_HOST_CMD && host_ok && byte_done;
  assign wr_data = acc && pwrite && paddr == `CLD_OFF_HOST_DATA && host_ok && byte_done;
  assign rd_data = acc && !pwrite && paddr == `CLD_OFF_HOST_DATA && host_ok;
  cld_cmd_decode u_dec (
    .cmd_byte(byte_in),
    .cmd(cmd)
  );
  logic cmd_go;
  assign cmd_go = wr_cmd;
  cld_busy_timer #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_busy (
    .pclk(pclk),
    .presetn(presetn),
    .start(wr_cmd || wr_data || rd_data),
    .start_long(wr_cmd && (cmd.kind == CLD_I_CLEAR || cmd.kind == CLD_I_HOME)),
    .busy(busy_flag)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nib_half_q <= 1'b0;
      nib_hi_q <= 4'h0;
    end
    else if (acc && pwrite && !mode_q.bus_width_select && host_ok &&
             (paddr == `CLD_OFF_HOST_CMD || paddr == `CLD_OFF_HOST_DATA))
    begin
      nib_half_q <= !nib_half_q;
      nib_hi_q <= pwdata[7:4];
    end
    else if (mode_q.bus_width_select)
      nib_half_q <= 1'b0;
  end
  // ----------------------------------------
  // address counter arithmetic
  // ----------------------------------------
  // step in a direction, keeping text addresses inside the mapped ranges
  function automatic logic [6:0] step_ac(input logic [6:0] ac, input logic up, input logic glyph,
                                         input logic two);
    logic [6:0] r;
    r = 7'h0;
    if (glyph)
      r = {1'b0, 6'(up ? ac[5:0] + 6'h1 : ac[5:0] - 6'h1)};
    else if (!two)
      r = up ? (ac == `CLD_ONE_LINE_LAST ? 7'h00 : ac + 7'h1)
             : (ac == 7'h00 ? `CLD_ONE_LINE_LAST : ac - 7'h1);
    else if (up)
      r = ac == `CLD_LINE1_LAST ? `CLD_LINE2_FIRST :
          (ac == `CLD_LINE2_LAST ? 7'h00 : ac + 7'h1);
    else
      r = ac == `CLD_LINE2_FIRST ? `CLD_LINE1_LAST :
          (ac == 7'h00 ? `CLD_LINE2_LAST : ac - 7'h1);
    return r;
  endfunction
  function automatic logic [6:0] fit_text(input logic [6:0] a, input logic two);
    logic [6:0] r;
    r = a;
    if (!two && a > `CLD_ONE_LINE_LAST)
      r = 7'h00;
    else if (two && a > `CLD_LINE1_LAST && a < `CLD_LINE2_FIRST)
      r = `CLD_LINE2_FIRST;
    else if (two && a > `CLD_LINE2_LAST)
      r = 7'h00;
    return r;
  endfunction
  logic [6:0] ac_next;
  assign ac_next = step_ac(address_counter_q, mode_q.entry_inc, glyph_sel_q, mode_q.two_line);
  logic [6:0] cur_next;
  assign cur_next = step_ac(address_counter_q, byte_in[2], 1'b0, mode_q.two_line);
  // ----------------------------------------
  // mode bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= '{entry_inc: 1'b1, bus_width_select: 1'b1, default: 1'b0};
    else if (cmd_go)
    begin
      unique case (cmd.kind)
        CLD_I_CLEAR:
          mode_q.entry_inc <= 1'b1;
        CLD_I_ENTRY:
        begin
          mode_q.entry_inc <= cmd.arg[1];
          mode_q.entry_shift <= cmd.arg[0];
        end
        CLD_I_DISP:
        begin
          mode_q.disp_on <= cmd.arg[2];
          mode_q.cursor_on <= cmd.arg[1];
          mode_q.blink_on <= cmd.arg[0];
        end
        CLD_I_FUNC:
        begin
          mode_q.bus_width_select <= cmd.arg[4];
          mode_q.two_line <= cmd.arg[3];
          mode_q.font_tall <= cmd.arg[3] ? 1'b0 : cmd.arg[2];
        end
        default:
          mode_q <= mode_q;
      endcase
    end
  end
  // ----------------------------------------
  // address counter, ram select, display shift
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      address_counter_q <= `CLD_AC_HOME;
      glyph_sel_q <= 1'b0;
      shift_q <= 7'h0;
    end
    else if (cmd_go)
    begin
      unique case (cmd.kind)
        CLD_I_CLEAR, CLD_I_HOME:
        begin
          address_counter_q <= `CLD_AC_HOME;
          glyph_sel_q <= 1'b0;
          shift_q <= 7'h0;
        end
        CLD_I_SHIFT:
          if (cmd.arg[3])
            shift_q <= cmd.arg[2] ? shift_q + 7'h1 : shift_q - 7'h1;
          else
            address_counter_q <= cur_next;
        CLD_I_GLYPH_ADDR:
        begin
          address_counter_q <= {1'b0, cmd.arg[5:0]};
          glyph_sel_q <= 1'b1;
        end
        CLD_I_TEXT_ADDR:
        begin
          address_counter_q <= fit_text(cmd.arg, mode_q.two_line);
          glyph_sel_q <= 1'b0;
        end
        default:
          address_counter_q <= address_counter_q;
      endcase
    end
    else if (wr_data || rd_data)
    begin
      address_counter_q <= ac_next;
      // display write shifts left on increment, right on decrement
      if (wr_data && !glyph_sel_q && mode_q.entry_shift)
        shift_q <= mode_q.entry_inc ? shift_q - 7'h1 : shift_q + 7'h1;
    end
  end
  // ----------------------------------------
  // ram arrays, clear sweep, read register
  // ----------------------------------------
  always_ff @(posedge pclk)
  begin
    if (clr_busy_q)
      text_ram[clr_idx_q] <= `CLD_SPACE_CODE;
    else if (wr_data && !glyph_sel_q)
      text_ram[address_counter_q] <= byte_in;
    if (wr_data && glyph_sel_q)
      glyph_ram[address_counter_q[5:0]] <= byte_in;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_busy_q <= 1'b0;
      clr_idx_q <= 7'h0;
    end
    else if (cmd_go && cmd.kind == CLD_I_CLEAR)
    begin
      clr_busy_q <= 1'b1;
      clr_idx_q <= 7'h0;
    end
    else if (clr_busy_q)
    begin
      clr_idx_q <= clr_idx_q + 7'h1;
      clr_busy_q <= clr_idx_q != 7'h7f;
    end
  end
  // the read register is filled by address set, cursor shift or data read,
  // so a read after a write returns the old byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_reg_q <= 8'h0;
      rd_valid_q <= 1'b0;
    end
    else if (cmd_go && cmd.kind == CLD_I_TEXT_ADDR)
    begin
      rd_reg_q <= text_ram[fit_text(cmd.arg, mode_q.two_line)];
      rd_valid_q <= 1'b1;
    end
    else if (cmd_go && cmd.kind == CLD_I_GLYPH_ADDR)
    begin
      rd_reg_q <= glyph_ram[cmd.arg[5:0]];
      rd_valid_q <= 1'b1;
    end
    else if (cmd_go && cmd.kind == CLD_I_SHIFT && !cmd.arg[3] && !glyph_sel_q)
    begin
      rd_reg_q <= text_ram[cur_next];
      rd_valid_q <= 1'b1;
    end
    else if (rd_data)
      rd_reg_q <= glyph_sel_q ? glyph_ram[ac_next[5:0]] : text_ram[ac_next];
    else if (wr_data)
      rd_reg_q <= rd_reg_q;
  end
  // ----------------------------------------
  // blink timer and display outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt_q <= 27'h0;
      blink_phase_q <= 1'b0;
    end
    else if (!mode_q.blink_on)
    begin
      blink_cnt_q <= 27'h0;
      blink_phase_q <= 1'b0;
    end
    else if (blink_cnt_q == 27'(BLINK_CYC - 1))
    begin
      blink_cnt_q <= 27'h0;
      blink_phase_q <= !blink_phase_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 27'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_out <= '0;
      disp_shift_out <= 7'h0;
      cursor_cell_lit <= 1'b0;
    end
    else
    begin
      mode_out <= mode_q;
      disp_shift_out <= shift_q;
      cursor_cell_lit <= mode_q.disp_on && mode_q.cursor_on && mode_q.blink_on && blink_phase_q;
    end
  end
  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= acc && paddr > `CLD_OFF_SHIFT;
      prdata_q <= 32'h0;
      if (acc && !pwrite)
      begin
        unique case (paddr)
          `CLD_OFF_HOST_CMD:
            prdata_q <= {24'h0, busy_flag || clr_busy_q, address_counter_q};
          `CLD_OFF_HOST_DATA:
            prdata_q <= {23'h0, rd_valid_q, rd_reg_q};
          `CLD_OFF_READBACK:
            prdata_q <= {23'h0, glyph_sel_q, rd_reg_q};
          `CLD_OFF_MODE:
            prdata_q <= {24'h0, mode_q};
          `CLD_OFF_SHIFT:
            prdata_q <= {25'h0, shift_q};
          default:
            prdata_q <= 32'h0;
        endcase
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_clear_home: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd.kind == CLD_I_CLEAR |=> address_counter_q == 7'h0 && mode_q.entry_inc && clr_busy_q)
    else $error("clear did not home");
  a_home_shift: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd.kind == CLD_I_HOME |=> shift_q == 7'h0 && address_counter_q == 7'h0)
    else $error("home left shift");
  a_ac_step: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data && !cmd_go |=> address_counter_q == $past(ac_next))
    else $error("counter did not step");
  a_wr_shift: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data && (glyph_sel_q || !mode_q.entry_shift) |=> $stable(shift_q))
    else $error("unexpected shift");
  a_disp_shift_ac: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd.kind == CLD_I_SHIFT && cmd.arg[3] |=> $stable(address_counter_q))
    else $error("display shift moved counter");
  a_line_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_go && cmd.kind == CLD_I_SHIFT && !cmd.arg[3] && cmd.arg[2] && mode_q.two_line
    && address_counter_q == 7'h27 |=> address_counter_q == 7'h40)
    else $error("no wrap to line two");
  a_busy_short: assert property (@(posedge pclk) disable iff (!presetn)
    wr_data |=> busy_flag [*4])
    else $error("busy too short");
  a_font_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q.two_line |-> !mode_q.font_tall)
    else $error("font with two lines");
  c_clear: cover property (@(posedge pclk) cmd_go && cmd.kind == CLD_I_CLEAR);
  c_nibble: cover property (@(posedge pclk) wr_data && !mode_q.bus_width_select);
  c_read: cover property (@(posedge pclk) rd_data && rd_valid_q);
endmodule // cld_lcd_decoder

// ===== tb/cld_host_model.sv
// Purpose: host processor model that reaches the decoder over apb
// Assumes: one transfer at a time, started just after a rising edge
// Notes: released psel and penable go low, paddr and pwdata show the inverse of their last value, pwrite keeps it
`timescale 1ns/100ps
module cld_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic nib = 1'b0;
  int tmo = 0;
  logic [31:0] q = 32'h0;
  logic e = 1'b0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // ----------------------------------------
  // bus cycle
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    if (n >= 64)
      tmo++;
    // an idle edge keeps two transfers from driving psel in one step
    @(posedge pclk);
  endtask
  // ----------------------------------------
  // host operations
  // ----------------------------------------
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, 12'h000, 32'h0);
      n++;
    end
    while (q[7] !== 1'b0 && n < 100);
    if (n >= 100)
      tmo++;
  endtask
  // the host sends two nibble writes when nib is set, so the width bit may be low
  task automatic send(input logic [11:0] a, input logic [7:0] b);
    wait_idle();
    if (nib)
    begin
      xfer(1'b1, a, {24'h0, b[7:4], 4'h0});
      xfer(1'b1, a, {24'h0, b[3:0], 4'h0});
    end
    else
      xfer(1'b1, a, {24'h0, b});
  endtask
endmodule // cld_host_model

// ===== tb/char_lcd_instruction_decoder_bench.sv
// Purpose: self-checking bench of the instruction decoder
// Assumes: shortened busy and blink counts
// Notes: every data read but the first, which checks the invalid flag, and one after a data write, which checks the stale byte, is preceded by an address set
`timescale 1ns/100ps
module char_lcd_instruction_decoder_bench
  import cld_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, cursor_cell_lit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [6:0] disp_shift_out;
  cld_mode_t mode_out;
  int err_count = 0;
  int n_tests = 0;
  initial
    forever #2 pclk = ~pclk;
  cld_lcd_decoder #(.LONG_CYC(40), .SHORT_CYC(8), .BLINK_CYC(16)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mode_out(mode_out), .disp_shift_out(disp_shift_out),
    .cursor_cell_lit(cursor_cell_lit));
  cld_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // ----------------------------------------
  // checks and helpers
  // ----------------------------------------
  task automatic final_report();
    err_count += u_host.tmo;
    if (err_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.send(12'h000, b);
  endtask
  task automatic dat(input logic [7:0] b);
    u_host.send(12'h004, b);
  endtask
  task automatic ac_is(input logic [6:0] a);
    u_host.wait_idle();
    chk(32'(u_host.q[7:0]), 32'(a));
  endtask
  task automatic rd_is(input logic [7:0] b);
    u_host.wait_idle();
    u_host.xfer(1'b0, 12'h004, 32'h0);
    chk(32'(u_host.q[8:0]), 32'({1'b1, b}));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ram();
    cmd(8'h85);
    dat(8'h41);
    dat(8'h42);
    ac_is(7'h07);
    cmd(8'h85);
    rd_is(8'h41);
    ac_is(7'h06);
    dat(8'h43);
    rd_is(8'h42);
    cmd(8'h04);
    cmd(8'h8a);
    dat(8'h55);
    ac_is(7'h09);
    cmd(8'h06);
  endtask
  task automatic t_shift();
    cmd(8'h07);
    cmd(8'h80);
    dat(8'h11);
    ac_is(7'h01);
    chk(32'(disp_shift_out), 32'h7f);
    cmd(8'h06);
    cmd(8'h18);
    ac_is(7'h01);
    chk(32'(disp_shift_out), 32'h7e);
    cmd(8'h1c);
    cmd(8'h14);
    ac_is(7'h02);
    chk(32'(disp_shift_out), 32'h7f);
    cmd(8'h02);
    ac_is(7'h00);
    chk(32'(disp_shift_out), 32'h0);
  endtask
  task automatic t_lines();
    cmd(8'h38);
    chk(32'(mode_out.two_line), 32'h1);
    cmd(8'ha7);
    dat(8'h66);
    ac_is(7'h40);
    cmd(8'ha7);
    cmd(8'h14);
    ac_is(7'h40);
    cmd(8'h34);
    chk(32'({mode_out.two_line, mode_out.font_tall}), 32'h1);
    cmd(8'h30);
  endtask
  task automatic t_display();
    int tg;
    logic last;
    cmd(8'h0f);
    chk(32'({mode_out.disp_on, mode_out.cursor_on, mode_out.blink_on}), 32'h7);
    tg = 0;
    last = cursor_cell_lit;
    repeat (100)
    begin
      @(posedge pclk);
      if (cursor_cell_lit !== last)
        tg++;
      last = cursor_cell_lit;
    end
    chk(32'(tg > 3), 32'h1);
    cmd(8'h0d);
    chk(32'({mode_out.entry_inc, mode_out.cursor_on}), 32'h2);
    chk(32'(cursor_cell_lit), 32'h0);
    cmd(8'h08);
    cmd(8'h85);
    rd_is(8'h41);
  endtask
  task automatic t_clear();
    cmd(8'h04);
    cmd(8'h01);
    u_host.xfer(1'b0, 12'h000, 32'h0);
    chk(32'(u_host.q[7]), 32'h1);
    // ignored: sent while busy
    u_host.xfer(1'b1, 12'h000, 32'h90);
    repeat (20) @(posedge pclk);
    u_host.xfer(1'b0, 12'h000, 32'h0);
    chk(32'(u_host.q[7]), 32'h1);
    ac_is(7'h00);
    chk(32'(mode_out.entry_inc), 32'h1);
    cmd(8'h85);
    rd_is(8'h20);
  endtask
  task automatic t_glyph_nib();
    cmd(8'h40);
    dat(8'h1f);
    ac_is(7'h01);
    cmd(8'h40);
    rd_is(8'h1f);
    cmd(8'h28);
    chk(32'(mode_out.bus_width_select), 32'h0);
    u_host.nib = 1'b1;
    cmd(8'h8c);
    ac_is(7'h0c);
    dat(8'h5a);
    cmd(8'h8c);
    rd_is(8'h5a);
    cmd(8'h38);
    u_host.nib = 1'b0;
    chk(32'(mode_out.bus_width_select), 32'h1);
    u_host.xfer(1'b0, 12'h014, 32'h0);
    chk(32'(u_host.e), 32'h1);
    u_host.xfer(1'b0, 12'h00c, 32'h0);
    chk(32'(u_host.e), 32'h0);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // mode_out is first loaded at the edge after release, so look one edge later
    repeat (2) @(posedge pclk);
    chk(32'(mode_out), 32'h84);
    u_host.xfer(1'b0, 12'h004, 32'h0);
    chk(32'(u_host.q[8]), 32'h0);
    t_ram();
    t_shift();
    t_lines();
    t_display();
    t_clear();
    t_glyph_nib();
    final_report();
  end
  initial
  begin
    repeat (60000)
    begin
      @(posedge pclk);
      if (u_host.tmo != 0)
        final_report();
    end
    err_count++;
    final_report();
  end
endmodule // char_lcd_instruction_decoder_bench
